// ==== i2cmb_pkg.sv ====
// Shared constants, state codes and carriers of the I2C master byte engine.
// Assumes a single 100 MHz system clock domain and open-drain bus pins.
package i2cmb_pkg;

  // Widths and reset values
  localparam int unsigned I2CMB_BYTE_W   = 8;
  localparam logic [7:0]  I2CMB_BYTE_RST = 8'h00;
  localparam logic [4:0]  I2CMB_PH_RST   = 5'h00;
  localparam logic [7:0]  I2CMB_BAUD_RST = 8'h00;

  // Phase counts: in transmit and receive, even phases hold SCL low, odd phases release it
  localparam logic [4:0]  I2CMB_PH_ONE      = 5'h01;
  localparam logic [4:0]  I2CMB_PH_TWO      = 5'h02;
  localparam logic [4:0]  I2CMB_PH_RX_LAST  = 5'h0f;
  localparam logic [4:0]  I2CMB_PH_ACK_LOW  = 5'h10;
  localparam logic [4:0]  I2CMB_PH_TX_LAST  = 5'h11;

  // Engine states, one-hot
  typedef enum logic [6:0] {
    I2CMB_IDLE    = 7'h01,
    I2CMB_START   = 7'h02,
    I2CMB_RESTART = 7'h04,
    I2CMB_STOP    = 7'h08,
    I2CMB_TX      = 7'h10,
    I2CMB_RX      = 7'h20,
    I2CMB_ACKSEQ  = 7'h40
  } i2cmb_state_t;

  // Sequence request bits, set by software, cleared by hardware
  typedef struct packed {
    logic start_request;
    logic restart_request;
    logic stop_request;
    logic ack_sequence_request;
    logic receive_request;
  } i2cmb_req_t;

  // Status flags seen by software
  typedef struct packed {
    logic buffer_full_flag;
    logic ack_status_bit;
    logic port_irq_flag;
    logic write_collision_flag;
    logic receive_overflow_flag;
  } i2cmb_flags_t;

  // Bus pin levels as sampled
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cmb_pins_t;

endpackage

// ==== i2cmb_sync.sv ====
// Two-stage synchroniser for the sampled SCL and SDA pin levels.
// Assumes the pins are asynchronous to sys_clk; idle bus reads high.
`timescale 1ns/1ps
`default_nettype none
module i2cmb_sync
  import i2cmb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire i2cmb_pins_t pins_async,
  output var  i2cmb_pins_t pins_sync
);

  typedef struct packed {
    i2cmb_pins_t meta;
    i2cmb_pins_t stable;
  } i2cmb_sync_t;

  i2cmb_sync_t st_r;
  i2cmb_sync_t st_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    st_nxt.meta   = pins_async;
    st_nxt.stable = st_r.meta;
  end

  // Released bus idles high, so reset to high
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pins_sync = st_r.stable;

endmodule
`default_nettype wire

// ==== i2cmb_baud.sv ====
// Baud counter: reloads from the reload value and counts down to rollover.
// Assumes the engine drives load and run from the same clock.
`timescale 1ns/1ps
`default_nettype none
module i2cmb_baud
  import i2cmb_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reload,
  input  wire logic       load,
  input  wire logic       run,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] cnt;
  } i2cmb_baud_t;

  i2cmb_baud_t st_r;
  i2cmb_baud_t st_nxt;

  // Rollover marks the end of one bit-phase period
  assign tick = run && !load && (st_r.cnt == I2CMB_BAUD_RST);

  // Load wins over counting; rollover reloads for the next phase
  always_comb
  begin
    st_nxt = st_r;
    if (load || tick)
    begin
      st_nxt.cnt = reload;
    end
    else if (run)
    begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r.cnt <= I2CMB_BAUD_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== i2cmb_engine.sv ====
// I2C master byte engine: transmit, receive, acknowledge, start, restart, stop.
// Assumes open-drain pins resolved outside; software drives pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module i2cmb_engine
  import i2cmb_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              scl_out,
  output logic              scl_oe,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic         xfer_buffer_wr,
  input  wire logic [7:0]   xfer_buffer_wdata,
  input  wire logic         xfer_buffer_rd,
  output logic [7:0]        xfer_buffer,
  input  wire i2cmb_req_t   req_set,
  output i2cmb_req_t        requests,
  input  wire logic         ack_data_value,
  input  wire logic [7:0]   baud_reload_value,
  input  wire logic         irq_clear,
  input  wire logic         collision_clear,
  input  wire logic         overflow_clear,
  output i2cmb_flags_t      flags,
  output logic              engine_idle
);

  typedef struct packed {
    i2cmb_state_t st;
    logic [4:0]   ph;
    logic [7:0]   bit_shifter;
    logic [7:0]   xbuf;
    i2cmb_req_t   req;
    i2cmb_flags_t flg;
    logic         scl_drive;
    logic         sda_drive;
    logic         scl_wait;
    logic         pin_level;
    logic         idle;
  } i2cmb_eng_t;

  i2cmb_eng_t  st_r;
  i2cmb_eng_t  st_nxt;
  i2cmb_pins_t pins_s;
  logic        baud_load;
  logic        baud_run;
  logic        baud_tick;

  // Pin levels pass two flip-flops before any logic reads them
  i2cmb_sync u_sync (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pins_async ({scl_in, sda_in}),
    .pins_sync  (pins_s)
  );

  // Counter runs only in an active sequence and not while SCL is stretched
  i2cmb_baud u_baud (
    .sys_clk (sys_clk),
    .rst     (rst),
    .reload  (baud_reload_value),
    .load    (baud_load),
    .run     (baud_run),
    .tick    (baud_tick)
  );

  // Drive low on SDA for a given bit value
  function automatic logic sda_low_for(input logic bit_val);
    sda_low_for = !bit_val;
  endfunction

  // Reload on entry to a sequence and once a released SCL reads high
  always_comb
  begin
    baud_run  = (st_r.st != I2CMB_IDLE) && !st_r.scl_wait;
    baud_load = (st_r.st == I2CMB_IDLE) && (|req_set || xfer_buffer_wr); // Inputs: no loop
    if (st_r.scl_wait && pins_s.scl)
    begin
      baud_load = 1'b1;
    end
  end

  // Next-state logic of the whole engine
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.pin_level = 1'b0;

    // Software clears; a hardware set later in this process wins
    if (irq_clear)
    begin
      st_nxt.flg.port_irq_flag = 1'b0;
    end
    if (collision_clear)
    begin
      st_nxt.flg.write_collision_flag = 1'b0;
    end
    if (overflow_clear)
    begin
      st_nxt.flg.receive_overflow_flag = 1'b0;
    end
    if (xfer_buffer_rd)
    begin
      st_nxt.flg.buffer_full_flag = 1'b0;
    end

    // Stretch release: counting resumes once SCL reads high
    if (st_r.scl_wait && pins_s.scl)
    begin
      st_nxt.scl_wait = 1'b0;
    end

    unique case (st_r.st)
      I2CMB_IDLE:
      begin
        // No queuing: one request per idle period, fixed priority
        st_nxt.ph = I2CMB_PH_RST;
        if (req_set.start_request)
        begin
          st_nxt.st                = I2CMB_START;
          st_nxt.req.start_request = 1'b1;
          st_nxt.scl_drive         = 1'b0;
          st_nxt.sda_drive         = 1'b0;
          st_nxt.scl_wait          = 1'b1;
        end
        else if (req_set.restart_request)
        begin
          st_nxt.st                  = I2CMB_RESTART;
          st_nxt.req.restart_request = 1'b1;
          st_nxt.scl_drive           = 1'b1;
          st_nxt.sda_drive           = 1'b0;
        end
        else if (req_set.stop_request)
        begin
          st_nxt.st               = I2CMB_STOP;
          st_nxt.req.stop_request = 1'b1;
          st_nxt.scl_drive        = 1'b1;
          st_nxt.sda_drive        = 1'b1;
        end
        else if (req_set.ack_sequence_request)
        begin
          st_nxt.st                       = I2CMB_ACKSEQ;
          st_nxt.req.ack_sequence_request = 1'b1;
          st_nxt.scl_drive                = 1'b1;
          st_nxt.sda_drive                = sda_low_for(ack_data_value);
        end
        else if (req_set.receive_request)
        begin
          st_nxt.st                  = I2CMB_RX;
          st_nxt.req.receive_request = 1'b1;
          st_nxt.scl_drive           = 1'b1;
          st_nxt.sda_drive           = 1'b0;
        end
        else if (xfer_buffer_wr)
        begin
          // Address or data byte, MSB first on SDA
          st_nxt.st                   = I2CMB_TX;
          st_nxt.xbuf                 = xfer_buffer_wdata;
          st_nxt.bit_shifter          = xfer_buffer_wdata;
          st_nxt.flg.buffer_full_flag = 1'b1;
          st_nxt.scl_drive            = 1'b1;
          st_nxt.sda_drive            = sda_low_for(xfer_buffer_wdata[7]);
        end
      end

      I2CMB_START:
      begin
        // SDA falls while SCL high, then a full period of hold
        if (baud_tick && (st_r.ph == I2CMB_PH_RST))
        begin
          st_nxt.sda_drive = 1'b1;
          st_nxt.ph        = I2CMB_PH_ONE;
        end
        else if (baud_tick)
        begin
          st_nxt.scl_drive          = 1'b1;
          st_nxt.req.start_request  = 1'b0;
          st_nxt.flg.port_irq_flag  = 1'b1;
          st_nxt.st                 = I2CMB_IDLE;
        end
      end

      I2CMB_RESTART:
      begin
        // SDA released with SCL low, SCL released, SDA falls, SCL low
        if (baud_tick && (st_r.ph == I2CMB_PH_RST))
        begin
          st_nxt.scl_drive = 1'b0;
          st_nxt.scl_wait  = 1'b1;
          st_nxt.ph        = I2CMB_PH_ONE;
        end
        else if (baud_tick && (st_r.ph == I2CMB_PH_ONE))
        begin
          st_nxt.sda_drive = 1'b1;
          st_nxt.ph        = I2CMB_PH_TWO;
        end
        else if (baud_tick)
        begin
          st_nxt.scl_drive           = 1'b1;
          st_nxt.req.restart_request = 1'b0;
          st_nxt.flg.port_irq_flag   = 1'b1;
          st_nxt.st                  = I2CMB_IDLE;
        end
      end

      I2CMB_STOP:
      begin
        // SDA low, SCL released, SDA released, one period of bus free
        if (baud_tick && (st_r.ph == I2CMB_PH_RST))
        begin
          st_nxt.scl_drive = 1'b0;
          st_nxt.scl_wait  = 1'b1;
          st_nxt.ph        = I2CMB_PH_ONE;
        end
        else if (baud_tick && (st_r.ph == I2CMB_PH_ONE))
        begin
          st_nxt.sda_drive = 1'b0;
          st_nxt.ph        = I2CMB_PH_TWO;
        end
        else if (baud_tick)
        begin
          st_nxt.req.stop_request  = 1'b0;
          st_nxt.flg.port_irq_flag = 1'b1;
          st_nxt.st                = I2CMB_IDLE;
        end
      end

      I2CMB_ACKSEQ:
      begin
        // One clock with the chosen acknowledge level on SDA
        if (baud_tick && (st_r.ph == I2CMB_PH_RST))
        begin
          st_nxt.scl_drive = 1'b0;
          st_nxt.scl_wait  = 1'b1;
          st_nxt.ph        = I2CMB_PH_ONE;
        end
        else if (baud_tick)
        begin
          st_nxt.scl_drive                = 1'b1;
          st_nxt.req.ack_sequence_request = 1'b0;
          st_nxt.flg.port_irq_flag        = 1'b1;
          st_nxt.st                       = I2CMB_IDLE;
        end
      end

      I2CMB_TX:
      begin
        // Bit changes a cycle after SCL falls for hold; needs a reload of 1 or more
        if (!st_r.ph[0] && !baud_tick)
        begin
          if (st_r.ph == I2CMB_PH_ACK_LOW)
          begin
            st_nxt.sda_drive = 1'b0;
          end
          else
          begin
            st_nxt.sda_drive = sda_low_for(st_r.bit_shifter[7]);
          end
        end
        if (baud_tick && !st_r.ph[0])
        begin
          // Low period over: release SCL, SDA unchanged through high
          st_nxt.scl_drive = 1'b0;
          st_nxt.scl_wait  = 1'b1;
          st_nxt.ph        = st_r.ph + 5'h01;
        end
        else if (baud_tick && (st_r.ph == I2CMB_PH_TX_LAST))
        begin
          // Ninth clock done: capture answer, park with SCL low
          st_nxt.flg.ack_status_bit = pins_s.sda;
          st_nxt.scl_drive          = 1'b1;
          st_nxt.flg.port_irq_flag  = 1'b1;
          st_nxt.st                 = I2CMB_IDLE;
        end
        else if (baud_tick)
        begin
          // SCL falls; next bit goes out only after the fall
          st_nxt.scl_drive   = 1'b1;
          st_nxt.bit_shifter = {st_r.bit_shifter[6:0], 1'b0};
          st_nxt.ph          = st_r.ph + 5'h01;
          if (st_nxt.ph == I2CMB_PH_ACK_LOW)
          begin
            st_nxt.flg.buffer_full_flag = 1'b0;
          end
        end
      end

      I2CMB_RX:
      begin
        if (baud_tick && !st_r.ph[0])
        begin
          st_nxt.scl_drive = 1'b0;
          st_nxt.scl_wait  = 1'b1;
          st_nxt.ph        = st_r.ph + 5'h01;
        end
        else if (baud_tick)
        begin
          // Sample at the end of the high period, MSB first
          st_nxt.bit_shifter = {st_r.bit_shifter[6:0], pins_s.sda};
          st_nxt.scl_drive   = 1'b1;
          st_nxt.ph          = st_r.ph + 5'h01;
          if (st_r.ph == I2CMB_PH_RX_LAST)
          begin
            // Old byte unread: flag overflow, newer byte still lands
            if (st_r.flg.buffer_full_flag && !xfer_buffer_rd)
            begin
              st_nxt.flg.receive_overflow_flag = 1'b1;
            end
            st_nxt.xbuf                 = {st_r.bit_shifter[6:0], pins_s.sda};
            st_nxt.flg.buffer_full_flag = 1'b1;
            st_nxt.flg.port_irq_flag    = 1'b1;
            st_nxt.req.receive_request  = 1'b0;
            st_nxt.st                   = I2CMB_IDLE;
          end
        end
      end
    endcase

    // Any buffer write outside idle is refused and flagged
    if (xfer_buffer_wr && (st_r.st != I2CMB_IDLE))
    begin
      st_nxt.flg.write_collision_flag = 1'b1;
    end

    st_nxt.idle = (st_nxt.st == I2CMB_IDLE);
  end

  // Whole state in one register; bus released and idle after reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r.st          <= I2CMB_IDLE;
      st_r.ph          <= I2CMB_PH_RST;
      st_r.bit_shifter <= I2CMB_BYTE_RST;
      st_r.xbuf        <= I2CMB_BYTE_RST;
      st_r.req         <= '0;
      st_r.flg         <= '0;
      st_r.scl_drive   <= 1'b0;
      st_r.sda_drive   <= 1'b0;
      st_r.scl_wait    <= 1'b0;
      st_r.pin_level   <= 1'b0;
      st_r.idle        <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Open-drain: pins only ever pulled low, level fixed at zero
  assign scl_out     = st_r.pin_level;
  assign sda_out     = st_r.pin_level;
  assign scl_oe      = st_r.scl_drive;
  assign sda_oe      = st_r.sda_drive;
  assign xfer_buffer = st_r.xbuf;
  assign requests    = st_r.req;
  assign flags       = st_r.flg;
  assign engine_idle = st_r.idle;

endmodule
`default_nettype wire

// ==== i2cmb_checker.sv ====
// Concurrent checks on the ports of the I2C master byte engine.
// Assumes a baud reload of 2 or more, so the ninth high phase spans 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module i2cmb_checker
  import i2cmb_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire logic         sda_in,
  input wire logic         scl_oe,
  input wire logic         sda_oe,
  input wire logic         xfer_buffer_wr,
  input wire logic         xfer_buffer_rd,
  input wire i2cmb_req_t   req_set,
  input wire i2cmb_req_t   requests,
  input wire logic         collision_clear,
  input wire i2cmb_flags_t flags,
  input wire logic         engine_idle
);
  logic       scl_oe_q;
  logic [3:0] falls;
  wire        busy_tx = !engine_idle && requests == 5'h00;

  // SCL falls inside a transmit; the eighth one opens the ack slot
  always_ff @(posedge sys_clk)
  begin
    scl_oe_q <= scl_oe;
    if (rst || engine_idle)
      falls <= 4'h0;
    else if (scl_oe && !scl_oe_q)
      falls <= falls + 4'h1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Write priority is below every request, hence the req_set term
  write_starts_a:
    assert property (engine_idle && xfer_buffer_wr && req_set == 5'h00 |=>
      flags.buffer_full_flag && !engine_idle) else $error("idle write did not start");
  collision_set_a:
    assert property (!engine_idle && xfer_buffer_wr |=> flags.write_collision_flag)
      else $error("busy write not flagged");
  collision_hold_a:
    assert property (flags.write_collision_flag && !collision_clear |=>
      flags.write_collision_flag) else $error("collision flag dropped");
  sda_steady_a:
    assert property (busy_tx && !scl_oe |=> scl_oe || $stable(sda_oe))
      else $error("data moved while clock high");
  sda_hold_a:
    assert property (busy_tx && $rose(scl_oe) |-> $stable(sda_oe))
      else $error("data moved with the clock fall");
  ack_release_a:
    assert property (busy_tx && falls == 4'h8 |-> !sda_oe && !flags.buffer_full_flag)
      else $error("ack slot not released");
  ack_status_a:
    assert property ($rose(engine_idle) && falls == 4'h8 |-> scl_oe &&
      flags.port_irq_flag && flags.ack_status_bit == $past(sda_in, 3))
      else $error("ack status or end of byte wrong");
  seq_done_a:
    assert property ($fell(|requests) |-> flags.port_irq_flag)
      else $error("sequence ended without interrupt");
  rx_done_a:
    assert property ($fell(requests.receive_request) |-> flags.buffer_full_flag &&
      flags.port_irq_flag && scl_oe) else $error("receive end wrong");
  rx_refuse_a:
    assert property (!engine_idle && req_set.receive_request && !requests.receive_request
      |=> !requests.receive_request) else $error("busy receive request taken");
  read_clears_a:
    assert property (engine_idle && xfer_buffer_rd && !xfer_buffer_wr |=>
      !flags.buffer_full_flag) else $error("read left buffer full");
  overflow_a:
    assert property ($fell(requests.receive_request) && $past(flags.buffer_full_flag) &&
      !$past(xfer_buffer_rd) |-> flags.receive_overflow_flag) else $error("no overflow");

  // Main scenarios reached
  tx_cov: cover property ($rose(engine_idle) && falls == 4'h8);
  ovf_cov: cover property ($rose(flags.receive_overflow_flag));
  col_cov: cover property ($rose(flags.write_collision_flag));
endmodule

bind i2cmb_engine i2cmb_checker u_chk (
  .sys_clk(sys_clk), .rst(rst), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .xfer_buffer_wr(xfer_buffer_wr), .xfer_buffer_rd(xfer_buffer_rd), .req_set(req_set),
  .requests(requests), .collision_clear(collision_clear), .flags(flags),
  .engine_idle(engine_idle)
);
`default_nettype wire

// ==== i2cmb_slave.sv ====
// Behavioural I2C slave: acks its address, takes writes, serves reads.
// Assumes resolved open-drain wires with pull-ups around it.
`timescale 1ns/1ps
`default_nettype none
module i2cmb_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  input  wire logic       stretch,
  output logic            sda_pull,
  output logic            scl_pull,
  output logic [7:0]      got
);
  logic [3:0] r = 4'h0;
  logic [7:0] sr;
  logic [7:0] tx;
  logic       sel = 1'b0;
  logic       rw = 1'b0;
  logic       first = 1'b0;

  initial
  begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    got = 8'h00;
  end
  // Start and stop framing
  always @(negedge sda)
    if (scl)
    begin
      r = 4'h0;
      first = 1'b1;
      sel = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      sel = 1'b0;
  // Sample on the rise only, so the master's data is settled
  always @(posedge scl)
  begin
    if (r < 4'h8)
      sr = {sr[6:0], sda};
    r = r + 4'h1;
  end
  // Drive only after the fall, holding through the high phase
  always @(negedge scl)
  begin
    if (r == 4'h9)
    begin
      r = 4'h0;
      first = 1'b0;
    end
    if (r == 4'h8)
    begin
      if (first)
      begin
        sel = sr[7:1] == ADDR || sr[7:1] == 7'h00;
        rw = sr[0];
      end
      got = sr;
    end
    tx = (r == 4'h0) ? rd_byte : {tx[6:0], 1'b0};
    sda_pull = (r == 4'h8) ? sel & (first | !rw) : sel & rw & !first & !tx[7];
    if (stretch)
    begin
      scl_pull = 1'b1;
      #300 scl_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the I2C master byte engine against a slave model.
// Assumes the engine's pins resolve as open drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tb
  import i2cmb_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       xfer_buffer_wr = 1'b0;
  logic       xfer_buffer_rd = 1'b0;
  logic [7:0] xfer_buffer_wdata = 8'h00;
  i2cmb_req_t req_set = 5'h00;
  logic       ack_data_value = 1'b0;
  logic [7:0] baud = 8'h03;
  logic       irq_clear = 1'b0;
  logic       collision_clear = 1'b0;
  logic       overflow_clear = 1'b0;
  logic       stretch = 1'b0;
  logic [7:0] rd_byte = 8'h3c;
  logic scl_oe, sda_oe, s_scl, s_sda, engine_idle;
  logic [7:0] xfer_buffer, got;
  logic scl_o, sda_o;
  i2cmb_req_t requests;
  i2cmb_flags_t flags;
  int n_fail = 0;
  int samples_checked = 0;
  // Wired-AND of both parties, pull-ups give the high level
  wire scl_w = !(scl_oe | s_scl);
  wire sda_w = !(sda_oe | s_sda);
  wire [7:0] fl = {3'h0, flags};
  wire [7:0] rq = {3'h0, requests};

  always #5 sys_clk = ~sys_clk;

  i2cmb_engine u_dut (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_out(sda_o), .sda_oe(sda_oe), .xfer_buffer_wr(xfer_buffer_wr),
    .xfer_buffer_wdata(xfer_buffer_wdata), .xfer_buffer_rd(xfer_buffer_rd),
    .xfer_buffer(xfer_buffer), .req_set(req_set), .requests(requests),
    .ack_data_value(ack_data_value), .baud_reload_value(baud), .irq_clear(irq_clear),
    .collision_clear(collision_clear), .overflow_clear(overflow_clear), .flags(flags),
    .engine_idle(engine_idle));
  i2cmb_slave u_slv (.scl(scl_w), .sda(sda_w), .rd_byte(rd_byte), .stretch(stretch),
    .sda_pull(s_sda), .scl_pull(s_scl), .got(got));

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic req(input i2cmb_req_t r);
    @(posedge sys_clk);
    req_set <= r;
    @(posedge sys_clk);
    req_set <= 5'h00;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    xfer_buffer_wr <= 1'b1;
    xfer_buffer_wdata <= d;
    @(posedge sys_clk);
    xfer_buffer_wr <= 1'b0;
  endtask
  // Clear pulses: irq, collision, overflow, buffer read
  task automatic ctl(input logic [3:0] m);
    @(posedge sys_clk);
    {irq_clear, collision_clear, overflow_clear, xfer_buffer_rd} <= m;
    @(posedge sys_clk);
    {irq_clear, collision_clear, overflow_clear, xfer_buffer_rd} <= 4'h0;
  endtask
  // Bounded wait for completion, idle returning with the flag, then one cycle more
  task automatic wait_irq();
    int i;
    for (i = 0; i < 3000 && flags.port_irq_flag !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 3000)
    begin
      n_fail++;
      complete_run();
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_write();
    req(5'h10);
    wait_irq();
    chk(rq, 8'h00);
    ctl(4'h8);
    wr(8'h54);
    @(negedge sys_clk);
    chk(fl, 8'h10);
    wr(8'hff);
    @(negedge sys_clk);
    chk(fl, 8'h12);
    chk(xfer_buffer, 8'h54);
    wait_irq();
    chk(got, 8'h54);
    chk(fl, 8'h06);
    chk({7'h0, scl_oe}, 8'h01);
    chk({6'h0, scl_o, sda_o}, 8'h00);
    ctl(4'hc);
    stretch <= 1'b1;
    wr(8'ha5);
    wait_irq();
    chk(got, 8'ha5);
    chk(fl, 8'h04);
    stretch <= 1'b0;
    // Clear so the next sequence's wait sees its own completion
    ctl(4'h8);
  endtask
  task automatic t_nack();
    req(5'h08);
    wait_irq();
    ctl(4'h8);
    wr(8'h22);
    wait_irq();
    chk(fl, 8'h0c);
    ctl(4'h8);
    req(5'h04);
    req(5'h01);
    wait_irq();
    chk(rq, 8'h00);
    chk({6'h0, scl_w, sda_w}, 8'h03);
    ctl(4'h8);
  endtask
  task automatic t_read();
    rd_byte <= 8'h3c;
    req(5'h10);
    wait_irq();
    ctl(4'h8);
    wr(8'h55);
    wait_irq();
    chk(fl, 8'h04);
    ctl(4'h8);
    req(5'h01);
    req(5'h10);
    wr(8'h99);
    @(negedge sys_clk);
    chk(rq, 8'h01);
    chk(fl, 8'h02);
    chk(xfer_buffer, 8'h55);
    wait_irq();
    chk(xfer_buffer, 8'h3c);
    chk(fl, 8'h16);
    ctl(4'hc);
    rd_byte <= 8'hc3;
    ack_data_value <= 1'b0;
    req(5'h02);
    wait_irq();
    chk(rq, 8'h00);
    ctl(4'h8);
    req(5'h01);
    wait_irq();
    chk(xfer_buffer, 8'hc3);
    chk(fl, 8'h15);
    ctl(4'hb);
    @(negedge sys_clk);
    chk(fl, 8'h00);
    @(posedge sys_clk);
    ack_data_value <= 1'b1;
    req(5'h02);
    wait_irq();
    ctl(4'h8);
    req(5'h04);
    wait_irq();
    chk({6'h0, scl_w, sda_w}, 8'h03);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_write();
    t_nack();
    t_read();
    complete_run();
  end
endmodule
`default_nettype wire
